// [core/jtbs_pkg.sv]
// Shared constants and types for the scan test port
package jtbs_pkg;
    localparam int LOOP_PINS = 8;
    localparam int CHANNELS = 1;
    // Scan chain layout
    localparam int LOOP_IN_BASE = 0;
    localparam int LOOP_OUT_BASE = 1;
    localparam int LOOP_STRIDE = 2;
    localparam int LOOP_DIS_POS = 15;
    localparam int LOOP7_OUT_POS = 16;
    localparam int RX_FLOAT_POS = 22;
    localparam int CHAIN_LEN = 23;
    // Instruction register
    localparam int IR_LEN = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_IDCODE = 4'hE;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [31:0] ID_CODE_VALUE = 32'h0000_0001; // Arbitrary value
    localparam logic [2:0] TMS_RESET_RUN = 3'h5;
    typedef enum logic [3:0] {
        ST_RESET = 4'hF, ST_IDLE = 4'hC, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
        ST_SH_DR = 4'h2, ST_EX1_DR = 4'h1, ST_PA_DR = 4'h3, ST_EX2_DR = 4'h0,
        ST_UP_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'hE, ST_SH_IR = 4'hA,
        ST_EX1_IR = 4'h9, ST_PA_IR = 4'hB, ST_EX2_IR = 4'h8, ST_UP_IR = 4'hD
    } jtbs_state_t;
endpackage

// [core/jtbs_sync.sv]
// Two-flop synchroniser for scan pins
`timescale 1ns/100ps
module jtbs_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= '0;
            synced <= '0;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule

// [core/jtbs_tap.sv]
// Scan test access port with loopback pin boundary cells
// Functional notes
// - Sixteen-state controller stepped by mode on clock.
// - Reset state: pins normal, ID instruction loaded.
// - Idle held while mode-select low.
// - Capture data loads chain from pins.
// - Shift data moves selected register one place.
// - Update data latches chain into output stage.
// - Capture instruction loads fixed pattern.
// - Shift instruction moves instruction shifter one place.
// - Update instruction makes shifted instruction active.
// - Pause states hold register contents.
// - Exit states are transient scan-ending points.
// - Every loop pin has a scan cell; receive data outputs have none.
// - Two-way pins use capture and drive cells.
// - Chain shifts least significant bit first.
// - Loop pin n: cell 2n in, 2n+1 out, except pin 7 out at cell 16.
// - Drive-disable cell floats or drives loop pins.
// - Float cell tristates receive outputs.
`timescale 1ns/100ps
module jtbs_tap
    import jtbs_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Scan port pins
    input wire logic scanClk,
    input wire logic scanMode,
    input wire logic scanDataIn,
    output logic scanDataOut,
    output logic scanDataOutEn_n,
    // Loopback pins, functional side and pad side
    input wire logic [jtbs_pkg::LOOP_PINS-1:0] loopFuncOut,
    input wire logic loopFuncEn_n,
    input wire logic [jtbs_pkg::LOOP_PINS-1:0] loopPadIn,
    output logic [jtbs_pkg::LOOP_PINS-1:0] loopPadOut,
    output logic loopPadEn_n,
    // Receive outputs of channel 1, functional and pad side
    input wire logic [2:0] rxFuncOut,
    input wire logic rxFuncFloat,
    output logic [2:0] rxPadOut,
    output logic rxPadEn_n,
    // Status
    output logic [3:0] tapState,
    output logic testActive
);
    import jtbs_pkg::*;

    logic [2:0] pinSync;
    logic tckQ, tmsS, tdiS;
    logic rise, fall;
    jtbs_state_t state_q, state_d;
    logic [CHAIN_LEN-1:0] chain_q, upd_q;
    logic [IR_LEN-1:0] irSh_q, ir_q;
    logic [31:0] idSh_q;
    logic byp_q;
    logic tdo_q, tdoEn_q;
    logic [2:0] tmsRun_q;
    logic selChain, extest;
    logic [CHAIN_LEN-1:0] capVec;
    logic [LOOP_PINS-1:0] padSync;

    jtbs_sync #(.WIDTH(3)) uSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async({scanClk, scanMode, scanDataIn}),
        .synced(pinSync)
    );
    // Pad levels are asynchronous to the system clock
    jtbs_sync #(.WIDTH(LOOP_PINS)) uPadSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async(loopPadIn),
        .synced(padSync)
    );
    assign tmsS = pinSync[1];
    assign tdiS = pinSync[0];

    always_ff @(posedge clk_sys) begin
        if (rst) tckQ <= 1'b0;
        else tckQ <= pinSync[2];
    end
    assign rise = pinSync[2] & ~tckQ;
    assign fall = ~pinSync[2] & tckQ;

    // Controller graph, stepped on scan clock rise
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: state_d = tmsS ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tmsS ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tmsS ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tmsS ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_d = tmsS ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = tmsS ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: state_d = tmsS ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_d = tmsS ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: state_d = tmsS ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tmsS ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tmsS ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_d = tmsS ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = tmsS ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: state_d = tmsS ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_d = tmsS ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: state_d = tmsS ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) state_q <= ST_RESET;
        else if (rise) state_q <= state_d;
    end

    // Count of consecutive high mode samples, used only for checking
    always_ff @(posedge clk_sys) begin
        if (rst) tmsRun_q <= '0;
        else if (rise) begin
            if (!tmsS) tmsRun_q <= '0;
            else if (tmsRun_q != TMS_RESET_RUN) tmsRun_q <= tmsRun_q + 3'h1;
        end
    end

    assign selChain = (ir_q == IR_EXTEST) || (ir_q == IR_SAMPLE);
    assign extest = (ir_q == IR_EXTEST);

    // Capture vector; cells without an input capture their output stage
    always_comb begin
        capVec = upd_q;
        for (int n = 0; n < LOOP_PINS; n++) begin
            capVec[LOOP_IN_BASE + LOOP_STRIDE*n] = padSync[n];
        end
    end

    // Instruction path
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irSh_q <= IR_CAPTURE;
            ir_q <= IR_IDCODE;
        end else if (rise) begin
            case (state_q)
                ST_RESET: ir_q <= IR_IDCODE;
                ST_CAP_IR: irSh_q <= IR_CAPTURE;
                ST_SH_IR: irSh_q <= {tdiS, irSh_q[IR_LEN-1:1]};
                ST_UP_IR: ir_q <= irSh_q;
                default: irSh_q <= irSh_q;
            endcase
        end
    end

    // Data registers: chain, identity and bypass
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chain_q <= '0;
            idSh_q <= ID_CODE_VALUE;
            byp_q <= 1'b0;
        end else if (rise) begin
            case (state_q)
                ST_CAP_DR: begin
                    if (selChain) chain_q <= capVec;
                    idSh_q <= ID_CODE_VALUE;
                    byp_q <= 1'b0;
                end
                ST_SH_DR: begin
                    // LSB nearest the output, new bits enter at the top
                    if (selChain)
                        chain_q <= {tdiS, chain_q[CHAIN_LEN-1:1]};
                    else if (ir_q == IR_IDCODE)
                        idSh_q <= {tdiS, idSh_q[31:1]};
                    else byp_q <= tdiS;
                end
                default: chain_q <= chain_q;
            endcase
        end
    end

    // Parallel output stage
    always_ff @(posedge clk_sys) begin
        if (rst) upd_q <= '0;
        else if (rise && state_q == ST_UP_DR && selChain)
            upd_q <= chain_q;
    end

    // Serial output changes on falling scan clock only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tdo_q <= 1'b0;
            tdoEn_q <= 1'b0;
        end else if (fall) begin
            tdoEn_q <= (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
            if (state_q == ST_SH_IR) tdo_q <= irSh_q[0];
            else if (selChain) tdo_q <= chain_q[0];
            else if (ir_q == IR_IDCODE) tdo_q <= idSh_q[0];
            else tdo_q <= byp_q;
        end
    end
    assign scanDataOut = tdo_q;
    assign scanDataOutEn_n = ~tdoEn_q;

    // Pin muxing; functional path unless the test instruction is active, receive data always functional
    assign testActive = extest && state_q != ST_RESET;
    always_comb begin
        for (int n = 0; n < LOOP_PINS; n++) begin
            loopPadOut[n] = testActive ?
                upd_q[LOOP_OUT_BASE + LOOP_STRIDE*n] : loopFuncOut[n];
        end
        loopPadOut[LOOP_PINS-1] = testActive ?
            upd_q[LOOP7_OUT_POS] : loopFuncOut[LOOP_PINS-1];
    end
    assign loopPadEn_n = testActive ? upd_q[LOOP_DIS_POS] : loopFuncEn_n;
    assign rxPadOut = rxFuncOut;
    assign rxPadEn_n = testActive ? upd_q[RX_FLOAT_POS] : rxFuncFloat;
    assign tapState = state_q;

    AST_FIVE_HIGH_RESET: assert property (@(posedge clk_sys) disable iff (rst)
        rise && tmsS && tmsRun_q == 3'h4 |=> state_q == ST_RESET)
        else $error("five high mode cycles did not reset");
    AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        rise && !tmsS && state_q == ST_IDLE |=> state_q == ST_IDLE)
        else $error("idle left with mode low");
    AST_RESET_ID: assert property (@(posedge clk_sys) disable iff (rst)
        rise && state_q == ST_RESET |=> ir_q == IR_IDCODE)
        else $error("reset state did not load identity instruction");
    AST_CAP_IR: assert property (@(posedge clk_sys) disable iff (rst)
        rise && state_q == ST_CAP_IR |=> irSh_q == IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    AST_UP_IR: assert property (@(posedge clk_sys) disable iff (rst)
        rise && state_q == ST_UP_IR |=> ir_q == $past(irSh_q))
        else $error("instruction not updated");
    AST_CAP_DR: assert property (@(posedge clk_sys) disable iff (rst)
        rise && state_q == ST_CAP_DR && selChain
        |=> chain_q[LOOP_IN_BASE] == $past(padSync[0]))
        else $error("chain capture missed pin");
    AST_SHIFT_DR: assert property (@(posedge clk_sys) disable iff (rst)
        rise && state_q == ST_SH_DR && selChain
        |=> chain_q[CHAIN_LEN-2:0] == $past(chain_q[CHAIN_LEN-1:1]))
        else $error("chain did not shift toward output");
    AST_PAUSE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        rise && state_q == ST_PA_DR |=> $stable(chain_q))
        else $error("chain changed during pause");
    AST_UP_DR: assert property (@(posedge clk_sys) disable iff (rst)
        rise && state_q == ST_UP_DR && selChain |=> upd_q == $past(chain_q))
        else $error("output stage not updated");
    AST_TDO_EN: assert property (@(posedge clk_sys) disable iff (rst)
        !scanDataOutEn_n |-> $past(state_q == ST_SH_DR || state_q == ST_SH_IR,
        1) || $stable(scanDataOutEn_n))
        else $error("data out enabled outside shift");
    AST_LOOP_DIS: assert property (@(posedge clk_sys) disable iff (rst)
        testActive |-> loopPadEn_n == upd_q[LOOP_DIS_POS])
        else $error("loop drive disable not applied");
endmodule

// [sim/jtbs_tester.sv]
// Scan test controller model driving the scan port pins
`timescale 1ns/100ps
module jtbs_tester (
    // Timing reference
    input wire logic clk_sys,
    // Scan port
    output logic scanClk,
    output logic scanMode,
    output logic scanDataIn,
    input wire logic scanDataOut
);
    initial begin
        scanClk = 1'b0;
        scanMode = 1'b1;
        scanDataIn = 1'b0;
    end

    // Scan clock idles low between frames
    // Output sampled late in high phase: it only moves after a fall
    task automatic walk(input int n, input logic [63:0] tms,
            input logic [63:0] tdi, output logic [63:0] tdo);
        tdo = '0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            scanMode = tms[i];
            scanDataIn = tdi[i];
            repeat (4) @(negedge clk_sys);
            scanClk = 1'b1;
            repeat (4) @(negedge clk_sys);
            tdo[i] = scanDataOut;
            scanClk = 1'b0;
        end
    endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the scan test port
`timescale 1ns/100ps
module tb;
    import jtbs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic scanClk, scanMode, scanDataIn, scanDataOut, scanDataOutEn_n;
    logic [7:0] loopFuncOut = 8'h96;
    logic loopFuncEn_n = 1'b0;
    logic [7:0] loopPadIn = 8'h00;
    logic [7:0] loopPadOut;
    logic loopPadEn_n;
    logic [2:0] rxFuncOut = 3'h5;
    logic rxFuncFloat = 1'b0;
    logic [2:0] rxPadOut;
    logic rxPadEn_n;
    logic [3:0] tapState;
    logic testActive;
    logic [63:0] tdo;
    int nErrors = 0;
    int testsRun = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    jtbs_tap uut (.clk_sys, .rst, .scanClk, .scanMode, .scanDataIn,
        .scanDataOut, .scanDataOutEn_n, .loopFuncOut, .loopFuncEn_n,
        .loopPadIn, .loopPadOut, .loopPadEn_n, .rxFuncOut, .rxFuncFloat,
        .rxPadOut, .rxPadEn_n, .tapState, .testActive);
    jtbs_tester tester (.clk_sys, .scanClk, .scanMode, .scanDataIn,
        .scanDataOut);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finishTest();
        $display("Checks %0d, mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic test_reset();
        check(tapState, ST_RESET);
        check(scanDataOutEn_n, 1'b1);
        check(loopPadOut, loopFuncOut);
        check(rxPadOut, rxFuncOut);
        check(testActive, 1'b0);
        $display("test_reset done");
    endtask

    task automatic test_idle();
        tester.walk(7, 64'h0, 64'h0, tdo);
        check(tapState, ST_IDLE);
        $display("test_idle done");
    endtask

    // Shift split by a pause detour; captured pattern must survive it
    task automatic test_ir();
        tester.walk(15, 64'h3246, 64'h0, tdo);
        check({tdo[12], tdo[11], tdo[6], tdo[5]}, IR_CAPTURE);
        check(testActive, 1'b1);
        check(tapState, ST_IDLE);
        $display("test_ir done");
    endtask

    // Full chain pass: bit p enters at step 3+p
    task automatic test_dr(input logic [7:0] pinIn, input logic [7:0] outPat,
            input logic dis, input logic flt);
        logic [63:0] tdi;
        logic [7:0] got;
        tdi = '0;
        for (int n = 0; n < 7; n++)
            tdi[4 + 2 * n] = outPat[n];
        tdi[19] = outPat[7];
        tdi[18] = dis;
        tdi[25] = flt;
        @(negedge clk_sys);
        loopPadIn = pinIn;
        tester.walk(28, 64'h6000001, tdi, tdo);
        for (int n = 0; n < 7; n++)
            got[n] = tdo[3 + 2 * n];
        got[7] = tdo[17];
        check(got, pinIn);
        check(loopPadEn_n, dis);
        if (!dis)
            check(loopPadOut, outPat);
        check(rxPadEn_n, flt);
        $display("test_dr done");
    endtask

    task automatic test_five();
        tester.walk(3, 64'h1, 64'h0, tdo);
        tester.walk(5, 64'h1F, 64'h0, tdo);
        check(tapState, ST_RESET);
        check(testActive, 1'b0);
        check(loopPadOut, loopFuncOut);
        $display("test_five done");
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        test_reset();
        test_idle();
        test_ir();
        test_dr(8'h3C, 8'hA5, 1'b0, 1'b1);
        test_dr(8'hC3, 8'h5A, 1'b1, 1'b0);
        test_five();
        finishTest();
    end

    // Whole run is under 1000 system clocks
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nErrors++;
            finishTest();
        end
    end
endmodule
